//--- rtl/clb_regs.svh
// Purpose: Register offsets, field positions and sizes of the configurable logic block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Included by bare name from the package and the design files.
`ifndef CLB_REGS_SVH
`define CLB_REGS_SVH

`define CLB_NUM_BLOCKS      4
`define CLB_BLK_W           2
`define CLB_NUM_INPUTS      4
`define CLB_IN_W            2
`define CLB_NUM_ORIGINS     16
`define CLB_ORIGIN_W        4
`define CLB_LUT_ENTRIES     16
`define CLB_IDX_W           4

`define CLB_ORIGIN_FALSE    4'h0
`define CLB_ORIGIN_TRUE     4'h1
`define CLB_ORIGIN_EXT0     4'h2

`define CLB_OFS_BLOCK_PICK  12'h000
`define CLB_OFS_INPUT_PICK  12'h004
`define CLB_OFS_ORIGIN      12'h008
`define CLB_OFS_INVERT      12'h00c
`define CLB_OFS_FUNCTION    12'h010
`define CLB_OFS_TABLE_PICK  12'h014
`define CLB_OFS_INDEX       12'h018
`define CLB_OFS_BIT         12'h01c
`define CLB_OFS_WORD        12'h020
`define CLB_OFS_OUTPUTS     12'h024

`define CLB_FUNC_COMB       1'b0
`define CLB_FUNC_LATCHED    1'b1
`define CLB_TABLE_DATA      1'b0
`define CLB_TABLE_ENABLE    1'b1

`endif

//--- rtl/clb_pkg.sv
// Purpose: Types shared by the configurable logic block files.
// Assumes: clb_regs.svh gives all sizes.
// Notes:   Holds types only.
`include "clb_regs.svh"

package clb_pkg;

	// Source choice and inversion of one block input.
	typedef struct packed {
		logic [`CLB_ORIGIN_W-1:0] origin;
		logic                     invert;
	} clb_input_cfg_t;

	// Per-block configuration.
	typedef struct packed {
		clb_input_cfg_t [`CLB_NUM_INPUTS-1:0] inputs;
		logic                                 latched;
		logic [`CLB_LUT_ENTRIES-1:0]          table_data;
		logic [`CLB_LUT_ENTRIES-1:0]          table_enable;
	} clb_block_cfg_t;

	typedef enum logic [1:0] {
		CLB_APB_IDLE   = 2'b00,
		CLB_APB_ACCESS = 2'b01
	} clb_apb_state_t;

endpackage

//--- rtl/clb_cell.sv
// Purpose: One logic block: input selection, inversion, two truth tables, flip-flop.
// Assumes: Sources are synchronous to CLK; configuration is held stable.
// Notes:   The flip-flop clock is a block input, sampled and edge-detected on CLK.
`timescale 1ns/1ps
`default_nettype none
`include "clb_regs.svh"

module clb_cell (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire clb_pkg::clb_block_cfg_t       cfg,
	input  wire logic [`CLB_NUM_ORIGINS-1:0]   sources,
	output var  logic                          out
);

	logic [`CLB_NUM_INPUTS-1:0] in_val;
	logic [`CLB_IDX_W-1:0]      idx;
	logic                       data_bit;
	logic                       enable_bit;
	logic                       clk_prev_r;
	logic                       clk_now;
	logic                       ff_r;
	logic                       ff_nxt;
	logic                       fire;

	// Each input takes its chosen source; constants ignore the inversion setting.
	genvar g;
	generate
		for (g = 0; g < `CLB_NUM_INPUTS; g = g + 1) begin : g_in
			wire logic [`CLB_ORIGIN_W-1:0] o = cfg.inputs[g].origin;
			wire logic                     konst = (o == `CLB_ORIGIN_TRUE) || (o == `CLB_ORIGIN_FALSE);
			assign in_val[g] = konst ? (o == `CLB_ORIGIN_TRUE) :
				(sources[o] ^ cfg.inputs[g].invert);
		end
	endgenerate

	// Input k is index bit k: all low picks entry 0, all high the last entry.
	assign idx        = in_val;
	assign data_bit   = cfg.table_data[idx];
	assign enable_bit = cfg.table_enable[idx];

	// In latched mode input 0 is the flip-flop clock; an inverted input gives falling-edge action.
	assign clk_now = in_val[0];
	assign fire    = clk_now & ~clk_prev_r;
	assign ff_nxt  = (fire && enable_bit) ? data_bit : ff_r;

	// Edge detect and flip-flop.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clk_prev_r <= 1'b0;
			ff_r       <= 1'b0;
		end else begin
			clk_prev_r <= clk_now;
			ff_r       <= ff_nxt;
		end
	end

	// Registered output so the next block never sees a glitching table read.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			out <= 1'b0;
		end else begin
			out <= cfg.latched ? ff_nxt : data_bit;
		end
	end

endmodule

`default_nettype wire

//--- rtl/clb_top.sv
// Purpose: Bank of configurable logic blocks with an APB register slave.
// Assumes: APB master per the protocol; external sources synchronous to CLK.
// Notes:   Block outputs feed back as selectable sources of every block.
//
// Functional notes
// - Inversion true presents complemented chosen source.
// - Inversion ignored for constant true/false sources.
// - Clock input: rising, or falling when inverted.
// - Each table holds two-to-the-n entries.
// - Index zero all low; last all high.
// - Bit access uses index within selected table.
// - Word access writes whole table; bit k.
// - Data-pick table drives flip-flop data.
// - Enable-pick table drives flip-flop enable.
// - Table pick matters only in latched mode.
// - Constant true drives one, false zero.
`timescale 1ns/1ps
`default_nettype none
`include "clb_regs.svh"

module clb_top (
	input  wire logic                   CLK,
	input  wire logic                   RST_B,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [11:0]            PADDR,
	input  wire logic [31:0]            PWDATA,
	output var  logic [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire logic [13:0]            EXT_SOURCES,
	output logic [`CLB_NUM_BLOCKS-1:0]  BLOCK_OUT
);

	clb_pkg::clb_block_cfg_t [`CLB_NUM_BLOCKS-1:0] cfg_r;
	logic [`CLB_BLK_W-1:0]         block_pick_r;
	logic [`CLB_IN_W-1:0]          input_pick_r;
	logic [`CLB_NUM_BLOCKS-1:0]    dual_table_pick_r;
	logic [`CLB_IDX_W-1:0]         index_r [`CLB_NUM_BLOCKS];
	logic [`CLB_NUM_ORIGINS-1:0]   sources;
	logic [`CLB_NUM_BLOCKS-1:0]    outs;

	// Decode, qualified by the APB access phase.
	wire logic access   = PSEL && PENABLE;
	wire logic wr       = access && PWRITE;
	wire logic hit_blk  = (PADDR == `CLB_OFS_BLOCK_PICK);
	wire logic hit_inp  = (PADDR == `CLB_OFS_INPUT_PICK);
	wire logic hit_org  = (PADDR == `CLB_OFS_ORIGIN);
	wire logic hit_inv  = (PADDR == `CLB_OFS_INVERT);
	wire logic hit_fun  = (PADDR == `CLB_OFS_FUNCTION);
	wire logic hit_tpk  = (PADDR == `CLB_OFS_TABLE_PICK);
	wire logic hit_idx  = (PADDR == `CLB_OFS_INDEX);
	wire logic hit_bit  = (PADDR == `CLB_OFS_BIT);
	wire logic hit_wrd  = (PADDR == `CLB_OFS_WORD);
	wire logic hit_out  = (PADDR == `CLB_OFS_OUTPUTS);
	wire logic mapped   = hit_blk | hit_inp | hit_org | hit_inv | hit_fun | hit_tpk |
		hit_idx | hit_bit | hit_wrd | hit_out;

	// Selected block, input and table.
	wire clb_pkg::clb_block_cfg_t sel_cfg = cfg_r[block_pick_r];
	wire clb_pkg::clb_input_cfg_t sel_in  = sel_cfg.inputs[input_pick_r];
	wire logic [`CLB_IDX_W-1:0]   sel_idx = index_r[block_pick_r];
	wire logic use_enable = sel_cfg.latched && (dual_table_pick_r[block_pick_r] == `CLB_TABLE_ENABLE);
	wire logic [`CLB_LUT_ENTRIES-1:0] sel_table = use_enable ? sel_cfg.table_enable :
		sel_cfg.table_data;
	wire logic sel_konst = (sel_in.origin == `CLB_ORIGIN_TRUE) ||
		(sel_in.origin == `CLB_ORIGIN_FALSE);

	// Read mux; inversion reads zero while the source is a constant.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_blk) begin
			rd_mux[`CLB_BLK_W-1:0] = block_pick_r;
		end else if (hit_inp) begin
			rd_mux[`CLB_IN_W-1:0] = input_pick_r;
		end else if (hit_org) begin
			rd_mux[`CLB_ORIGIN_W-1:0] = sel_in.origin;
		end else if (hit_inv) begin
			rd_mux[0] = sel_in.invert && !sel_konst;
		end else if (hit_fun) begin
			rd_mux[0] = sel_cfg.latched;
		end else if (hit_tpk) begin
			rd_mux[0] = dual_table_pick_r[block_pick_r];
		end else if (hit_idx) begin
			rd_mux[`CLB_IDX_W-1:0] = sel_idx;
		end else if (hit_bit) begin
			rd_mux[0] = sel_table[sel_idx];
		end else if (hit_wrd) begin
			rd_mux[`CLB_LUT_ENTRIES-1:0] = sel_table;
		end else if (hit_out) begin
			rd_mux[`CLB_NUM_BLOCKS-1:0] = outs;
		end
	end

	// Zero-wait slave: every access completes in its first access cycle.
	assign PREADY  = 1'b1;
	assign PSLVERR = access && !mapped;

	// Read data register.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rd_mux;
		end
	end

	// Selectors.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			block_pick_r <= '0;
			input_pick_r <= '0;
		end else begin
			if (wr && hit_blk) begin
				block_pick_r <= PWDATA[`CLB_BLK_W-1:0];
			end
			if (wr && hit_inp) begin
				input_pick_r <= PWDATA[`CLB_IN_W-1:0];
			end
		end
	end

	// Per-block configuration storage.
	genvar b;
	generate
		for (b = 0; b < `CLB_NUM_BLOCKS; b = b + 1) begin : g_blk
			wire logic me = (int'(block_pick_r) == b) && wr;
			wire logic en_tbl = cfg_r[b].latched &&
				(dual_table_pick_r[b] == `CLB_TABLE_ENABLE);
			always_ff @(posedge CLK) begin
				if (!RST_B) begin
					cfg_r[b]             <= '0;
					index_r[b]           <= '0;
					dual_table_pick_r[b] <= `CLB_TABLE_DATA;
				end else if (me) begin
					if (hit_org) begin
						cfg_r[b].inputs[input_pick_r].origin <= PWDATA[`CLB_ORIGIN_W-1:0];
					end
					if (hit_inv && !sel_konst) begin
						cfg_r[b].inputs[input_pick_r].invert <= PWDATA[0];
					end
					if (hit_fun) begin
						cfg_r[b].latched <= PWDATA[0];
					end
					if (hit_tpk) begin
						dual_table_pick_r[b] <= PWDATA[0];
					end
					if (hit_idx) begin
						index_r[b] <= PWDATA[`CLB_IDX_W-1:0];
					end
					if (hit_bit && en_tbl) begin
						cfg_r[b].table_enable[index_r[b]] <= PWDATA[0];
					end else if (hit_bit) begin
						cfg_r[b].table_data[index_r[b]] <= PWDATA[0];
					end
					if (hit_wrd && en_tbl) begin
						cfg_r[b].table_enable <= PWDATA[`CLB_LUT_ENTRIES-1:0];
					end else if (hit_wrd) begin
						cfg_r[b].table_data <= PWDATA[`CLB_LUT_ENTRIES-1:0];
					end
				end
			end
			clb_cell u_cell (
				.clk     (CLK),
				.rst_b   (RST_B),
				.cfg     (cfg_r[b]),
				.sources (sources),
				.out     (outs[b])
			);
		end
	endgenerate

	// Source vector: two constants, ten externals, then every block output.
	assign sources   = {outs, EXT_SOURCES[9:0], 2'b10};
	assign BLOCK_OUT = outs;

endmodule

`default_nettype wire

//--- bench/clb_top_chk.sv
// Purpose: Port checks for the logic block bank.
// Assumes: Zero-wait APB slave; bench keeps block outputs out of the sources.
// Notes:   Bound to clb_top below.
`timescale 1ns/1ps
`default_nettype none

module clb_top_chk (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [13:0] EXT_SOURCES,
	input wire logic [3:0]  BLOCK_OUT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Bus phase decode; misaligned words count as unmapped.
	wire logic acc = PSEL && PENABLE;
	wire logic hit = PADDR <= 12'h024 && PADDR[1:0] == 2'h0;
	wire logic rd_setup = PSEL && !PENABLE && !PWRITE;

	AST_READY: assert property (acc |-> PREADY) else $error("no ready");
	AST_ERR: assert property (acc && !hit |-> PSLVERR) else $error("no slverr");
	AST_NOERR: assert property (acc && hit |-> !PSLVERR) else $error("bad slverr");
	AST_ERR_PHASE: assert property (PSLVERR |-> acc)
		else $error("slverr out of access");
	AST_RST_OUT: assert property ($rose(RST_B) |-> BLOCK_OUT == 4'h0)
		else $error("out not reset");
	AST_RD_HOLD: assert property (acc |=> $stable(PRDATA)) else $error("read data moved");
	AST_OUT_RD: assert property ((rd_setup && PADDR == 12'h024) ##1 acc
		|-> PRDATA == {28'h0, $past(BLOCK_OUT)}) else $error("outputs read wrong");
	// A table word has one bit per entry, so nothing may show above entry 15.
	AST_WORD_W: assert property ((rd_setup && PADDR == 12'h020) ##1 acc
		|-> PRDATA[31:16] == 16'h0000) else $error("word read too wide");
	// A single entry read carries its value in bit 0 alone.
	AST_BIT_W: assert property ((rd_setup && PADDR == 12'h01c) ##1 acc
		|-> PRDATA[31:1] == 31'h0) else $error("bit read too wide");
	// Quiet bus and steady sources leave no cause for an output change.
	AST_HOLD: assert property ((!PSEL && $stable(EXT_SOURCES)) [*4]
		|-> $stable(BLOCK_OUT)) else $error("output moved");
	cover property (acc && PSLVERR);
	cover property (acc && PWRITE && PADDR == 12'h020);
	cover property ($rose(BLOCK_OUT[0]));
endmodule

bind clb_top clb_top_chk u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .EXT_SOURCES(EXT_SOURCES), .BLOCK_OUT(BLOCK_OUT));
`default_nettype wire

//--- bench/tb_clb_top.sv
// Purpose: Self-checking bench for the logic block bank.
// Assumes: Random origins stay below 12, so no block feeds another.
// Notes:   A shadow of the tables predicts each combinational output; a fixed list gives the latched ones.
`timescale 1ns/1ps
`default_nettype none
`include "clb_regs.svh"

module tb_clb_top;
	logic        CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd, sd = 32'h0000b993;
	logic        PREADY, PSLVERR, err;
	logic [13:0] EXT_SOURCES = 14'h0;
	logic [3:0]  BLOCK_OUT, ev, org [4][4];
	logic        inv [4][4];
	logic [15:0] tbl [4];
	logic [2:0]  pat [9] = '{3'h0, 3'h6, 3'h7, 3'h0, 3'h1, 3'h4, 3'h5, 3'h7, 3'h6};
	logic        lat [9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	int          fail_count = 0, n_checks = 0;

	clb_top u_dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.EXT_SOURCES(EXT_SOURCES), .BLOCK_OUT(BLOCK_OUT));

	// Clock and a hang guard.
	initial forever #4 CLK = ~CLK;
	initial begin
		repeat (60000) @(posedge CLK);
		fail_count++;
		give_verdict();
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Table entry picked by the shadowed inputs of block b.
	function automatic logic exp_out(input int b, input logic [13:0] e);
		logic [3:0] i;
		for (int k = 0; k < 4; k++) begin
			i[k] = (org[b][k] < 4'h2) ? org[b][k][0] : e[org[b][k] - 4'h2] ^ inv[b][k];
		end
		return tbl[b][i];
	endfunction

	// One transfer, held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		if (PREADY !== 1'b1) begin
			fail_count++;
			give_verdict();
		end else begin
			rd = PRDATA;
			err = PSLVERR;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
		end
	endtask

	task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t word %h want %h", $time, g, x);
		end
	endtask

	task automatic chk_bit(input logic g, input logic x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t bit %b want %b", $time, g, x);
		end
	endtask

	// Sources change, then four edges let the registered paths settle.
	task automatic settle(input logic [13:0] v);
		EXT_SOURCES <= v;
		repeat (4) @(posedge CLK);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Random combinational setups, a bad address, then the registered dual table.
	initial begin
		repeat (5) @(posedge CLK);
		RST_B <= 1'b1;
		for (int t = 0; t < 6; t++) begin
			for (int b = 0; b < 4; b++) begin
				apb(1'b1, `CLB_OFS_BLOCK_PICK, 32'(b));
				for (int k = 0; k < 4; k++) begin
					sd = lfsr(sd);
					org[b][k] = sd[3:0] % 4'hc;
					inv[b][k] = sd[4] & (org[b][k] > 4'h1);
					apb(1'b1, `CLB_OFS_INPUT_PICK, 32'(k));
					apb(1'b1, `CLB_OFS_ORIGIN, {28'h0, org[b][k]});
					apb(1'b1, `CLB_OFS_INVERT, {31'h0, sd[4]});
					apb(1'b0, `CLB_OFS_INVERT, 32'h0);
					chk_word(rd, {31'h0, inv[b][k]});
				end
				sd = lfsr(sd);
				tbl[b] = sd[15:0];
				apb(1'b1, `CLB_OFS_INDEX, {28'h0, sd[23:20]});
				apb(1'b1, `CLB_OFS_TABLE_PICK, {31'h0, sd[16]});
				apb(1'b1, `CLB_OFS_WORD, {16'h0, tbl[b]});
				apb(1'b1, `CLB_OFS_BIT, {31'h0, sd[24]});
				tbl[b][sd[23:20]] = sd[24];
				apb(1'b0, `CLB_OFS_BIT, 32'h0);
				chk_word(rd, {31'h0, sd[24]});
				apb(1'b0, `CLB_OFS_WORD, 32'h0);
				chk_word(rd, {16'h0, tbl[b]});
			end
			for (int j = 0; j < 4; j++) begin
				sd = lfsr(sd);
				settle(j == 0 ? 14'h3fff : sd[13:0]);
				for (int b = 0; b < 4; b++) begin
					ev[b] = exp_out(b, EXT_SOURCES);
					chk_bit(BLOCK_OUT[b], ev[b]);
				end
			end
			apb(1'b0, `CLB_OFS_OUTPUTS, 32'h0);
			chk_word(rd, {28'h0, ev});
		end
		apb(1'b0, 12'h040, 32'h0);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0);
		// Block 0: input 0 clocks, input 1 is data, input 2 is enable.
		apb(1'b1, `CLB_OFS_BLOCK_PICK, 32'h0);
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `CLB_OFS_INPUT_PICK, 32'(k));
			apb(1'b1, `CLB_OFS_ORIGIN, (k == 3) ? 32'h0 : 32'(k + 2));
			apb(1'b1, `CLB_OFS_INVERT, 32'h0);
		end
		apb(1'b1, `CLB_OFS_FUNCTION, 32'h1);
		apb(1'b1, `CLB_OFS_TABLE_PICK, 32'h0);
		apb(1'b1, `CLB_OFS_WORD, 32'h0000cccc);
		apb(1'b1, `CLB_OFS_TABLE_PICK, 32'h1);
		apb(1'b1, `CLB_OFS_WORD, 32'h0000f0f0);
		apb(1'b0, `CLB_OFS_WORD, 32'h0);
		chk_word(rd, 32'h0000f0f0);
		apb(1'b0, `CLB_OFS_FUNCTION, 32'h0);
		chk_word(rd, 32'h00000001);
		apb(1'b0, `CLB_OFS_TABLE_PICK, 32'h0);
		chk_word(rd, 32'h00000001);
		// Input 3 was left on the constant false source.
		apb(1'b0, `CLB_OFS_ORIGIN, 32'h0);
		chk_word(rd, 32'h00000000);
		// Entry 5 of the enable table lies in its set bits 7:4, so it reads one.
		apb(1'b1, `CLB_OFS_INDEX, 32'h00000005);
		apb(1'b0, `CLB_OFS_INDEX, 32'h0);
		chk_word(rd, 32'h00000005);
		apb(1'b0, `CLB_OFS_BIT, 32'h0);
		chk_word(rd, 32'h00000001);
		for (int s = 0; s < 9; s++) begin
			if (s == 7) begin
				apb(1'b1, `CLB_OFS_INPUT_PICK, 32'h0);
				apb(1'b1, `CLB_OFS_INVERT, 32'h1);
			end
			settle({11'h0, pat[s]});
			if (s > 1) chk_bit(BLOCK_OUT[0], lat[s]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
